// file: core/dpmb_regs.svh
`ifndef DPMB_REGS_SVH
`define DPMB_REGS_SVH
// control-side byte offsets within the mailbox bank
`define DPMB_OUT_FIRST      4'h0
`define DPMB_IN_FIRST       4'h8
`define DPMB_IN_SEL_BIT     3
// processor control register fields (control side)
`define DPMB_PCR_CLR_CPU    0
`define DPMB_PCR_SET_DSP    1
// signal-processor external register numbers
`define DPMB_EXT_MBOX_LAST  3'h3
`define DPMB_EXT_ICR        3'h4
`define DPMB_EXT_CONV       3'h5
`define DPMB_EXT_ACR        3'h6
// interrupt control register fields
`define DPMB_ICR_REQ2       15
`define DPMB_ICR_REQ1       14
`define DPMB_ICR_REQ0       13
`define DPMB_ICR_MASK2      12
`define DPMB_ICR_MASK1      11
`define DPMB_ICR_MASK0      10
`define DPMB_ICR_CPU_IRQ    9
`define DPMB_ICR_GEN        8
`define DPMB_ICR_IPR_HI     7
`define DPMB_ICR_IPR_LO     5
`define DPMB_ICR_CLR2       4
`define DPMB_ICR_CLR1       3
`define DPMB_ICR_CLR0       2
// reset values
`define DPMB_BYTE_RST       8'h00
`define DPMB_WORD_RST       16'h0000
`endif

// file: core/dpmb_pkg.sv
package dpmb_pkg;
	// interrupt acceptance states of the signal processor side
	typedef enum logic [1:0] {DPMB_IDLE, DPMB_SERVICE} dpmb_isr_t;
	typedef logic [7:0]  dpmb_byte_t;
	typedef logic [15:0] dpmb_word_t;
endpackage

// file: core/dpmb_irq_arb.sv
`timescale 1ns/100ps
`include "dpmb_regs.svh"
// fixed-priority, non-nesting interrupt acceptance for the signal processor
module dpmb_irq_arb
(
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	// qualified requests, index 2 is highest
	input  wire logic [2:0] req_i,
	// end of service routine
	input  wire logic       isr_done_i,
	// accepted vector
	output logic            take_o,
	output logic [1:0]      vec_o,
	output logic            busy_o
);
	dpmb_pkg::dpmb_isr_t state_ff;
	logic                take_ff;
	logic [1:0]          vec_ff;

	// priority encode: highest line wins when several are pending together
	function automatic logic [1:0] pick(input logic [2:0] r);
		if (r[2])
			pick = 2'h2;
		else if (r[1])
			pick = 2'h1;
		else
			pick = 2'h0;
	endfunction

	// accept only while idle so a running routine is never interrupted
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= dpmb_pkg::DPMB_IDLE;
			take_ff  <= 1'b0;
			vec_ff   <= 2'h0;
		end
		else
		begin
			take_ff <= 1'b0;
			case (state_ff)
				dpmb_pkg::DPMB_IDLE:
					if (|req_i)
					begin
						take_ff  <= 1'b1;
						vec_ff   <= pick(req_i);
						state_ff <= dpmb_pkg::DPMB_SERVICE;
					end
				dpmb_pkg::DPMB_SERVICE:
					if (isr_done_i)
						state_ff <= dpmb_pkg::DPMB_IDLE;
				default:
					state_ff <= dpmb_pkg::DPMB_IDLE;
			endcase
		end
	end

	assign take_o = take_ff;
	assign vec_o  = vec_ff;
	assign busy_o = (state_ff == dpmb_pkg::DPMB_SERVICE);
endmodule

// file: core/dpmb_top.sv
// Behaviour
// - every external register access by the signal processor finishes in one cycle.
// - four 16-bit words are built from sixteen control-side byte registers.
// - word k reads out bytes 2k,2k+1 and writes in bytes 8+2k,9+2k.
// - one address per word; direction picks outgoing or incoming pair.
// - outgoing bytes 00-07 read/write by control, read-only by signal processor.
// - incoming bytes 08-0F read-only for control; only signal processor writes them.
// - interrupt control register is signal-processor only, except bits F and 9.
// - converter data writes go to D/A, reads come from A/D; control none.
// - analog control register is read/write, signal-processor only.
// - three request lines, line two highest, line zero lowest.
// - no new interrupt accepted while a service routine runs.
// - simultaneous requests: highest priority serviced first.
// - signal-processor mailbox interrupt set by control bit 1 write, cleared by clear bit.
`timescale 1ns/100ps
`include "dpmb_regs.svh"
module dpmb_top
(
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// control processor mailbox bank port
	input  wire logic        cpu_wr_i,
	input  wire logic [3:0]  cpu_addr_i,
	input  wire logic [7:0]  cpu_wdata_i,
	output logic      [7:0]  cpu_rdata_o,
	// control processor control register bits 1:0
	input  wire logic        cpu_pcr_wr_i,
	input  wire logic [1:0]  cpu_pcr_wdata_i,
	output logic      [1:0]  cpu_pcr_rdata_o,
	output logic             control_cpu_mailbox_irq_o,
	// signal processor external register port
	input  wire logic        dsp_rd_i,
	input  wire logic        dsp_wr_i,
	input  wire logic [2:0]  dsp_ext_i,
	input  wire logic [15:0] dsp_wdata_i,
	output logic      [15:0] dsp_rdata_o,
	// converter and timer events, same clock
	input  wire logic        adc_done_i,
	input  wire logic [7:0]  adc_data_i,
	input  wire logic        dac_tick_i,
	output logic      [9:0]  dac_data_o,
	output logic             dac_load_o,
	output logic      [15:0] analog_ctrl_o,
	// interrupt acceptance
	input  wire logic        isr_done_i,
	output logic             dsp_irq_take_o,
	output logic      [1:0]  dsp_irq_vec_o,
	output logic             dsp_irq_busy_o
);
	// sixteen bytes: 0-7 outgoing, 8-15 incoming
	dpmb_pkg::dpmb_byte_t mbox_ff [16];
	logic [7:0]  cpu_rdata_ff;
	logic [1:0]  cpu_pcr_rdata_ff;
	logic [15:0] dsp_rdata_ff;
	logic        cpu_irq_ff;
	logic        dsp_mailbox_irq_ff;
	logic        adc_irq_ff;
	logic        dac_irq_ff;
	logic [2:0]  mask_ff;
	logic        gen_en_ff;
	logic [2:0]  ipr_ff;
	logic [15:0] acr_ff;
	logic [9:0]  dac_ff;
	logic        dac_load_ff;
	logic [7:0]  adc_ff;
	logic        arb_take;
	logic [1:0]  arb_vec;
	logic        arb_busy;
	logic [2:0]  line_req;
	logic [15:0] icr_rd;
	logic        wr_icr;
	logic        clr2;
	logic        clr1;
	logic        clr0;

	// byte index of the high half of word k
	function automatic logic [3:0] byte_hi(input logic [1:0] k, input logic incoming);
		byte_hi = {incoming, k, 1'b0};
	endfunction

	assign wr_icr = dsp_wr_i && (dsp_ext_i == `DPMB_EXT_ICR);
	assign clr2   = wr_icr && dsp_wdata_i[`DPMB_ICR_CLR2];
	assign clr1   = wr_icr && dsp_wdata_i[`DPMB_ICR_CLR1];
	assign clr0   = wr_icr && dsp_wdata_i[`DPMB_ICR_CLR0];

	// mailbox storage, held until the owning side overwrites it
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < 16; i++)
				mbox_ff[i] <= `DPMB_BYTE_RST;
		end
		else
		begin
			// control writes only land in the outgoing half
			if (cpu_wr_i && !cpu_addr_i[`DPMB_IN_SEL_BIT])
				mbox_ff[cpu_addr_i] <= cpu_wdata_i;
			// signal processor write fills the incoming pair of the word
			if (dsp_wr_i && (dsp_ext_i <= `DPMB_EXT_MBOX_LAST))
			begin
				mbox_ff[byte_hi(dsp_ext_i[1:0], 1'b1)]        <= dsp_wdata_i[15:8];
				mbox_ff[byte_hi(dsp_ext_i[1:0], 1'b1) | 4'h1] <= dsp_wdata_i[7:0];
			end
		end
	end

	// control-side read data; reads have no side effect
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			cpu_rdata_ff <= `DPMB_BYTE_RST;
		else
			cpu_rdata_ff <= mbox_ff[cpu_addr_i];
	end

	// control mailbox interrupt: set by bit 9, cleared by pcr bit 0, set wins
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			cpu_irq_ff <= 1'b0;
		else if (wr_icr && dsp_wdata_i[`DPMB_ICR_CPU_IRQ])
			cpu_irq_ff <= 1'b1;
		else if (cpu_pcr_wr_i && cpu_pcr_wdata_i[`DPMB_PCR_CLR_CPU])
			cpu_irq_ff <= 1'b0;
	end

	// signal-processor mailbox request: set by control bit 1 write, set wins
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			dsp_mailbox_irq_ff <= 1'b0;
		else if (cpu_pcr_wr_i && cpu_pcr_wdata_i[`DPMB_PCR_SET_DSP])
			dsp_mailbox_irq_ff <= 1'b1;
		else if (clr2)
			dsp_mailbox_irq_ff <= 1'b0;
	end

	// converter and timer requests, set wins over clear
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			adc_irq_ff <= 1'b0;
			dac_irq_ff <= 1'b0;
		end
		else
		begin
			if (adc_done_i)
				adc_irq_ff <= 1'b1;
			else if (clr1)
				adc_irq_ff <= 1'b0;
			if (dac_tick_i)
				dac_irq_ff <= 1'b1;
			else if (clr0)
				dac_irq_ff <= 1'b0;
		end
	end

	// control-side view of the two shared bits
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			cpu_pcr_rdata_ff <= 2'h0;
		else
			cpu_pcr_rdata_ff <= {dsp_mailbox_irq_ff, cpu_irq_ff};
	end

	// interrupt control fields, reachable from the signal processor only
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			mask_ff   <= 3'h0;
			gen_en_ff <= 1'b0; // reset disables all interrupts globally
			ipr_ff    <= 3'h0;
		end
		else if (wr_icr)
		begin
			mask_ff   <= dsp_wdata_i[`DPMB_ICR_MASK2:`DPMB_ICR_MASK0];
			gen_en_ff <= dsp_wdata_i[`DPMB_ICR_GEN];
			ipr_ff    <= dsp_wdata_i[`DPMB_ICR_IPR_HI:`DPMB_ICR_IPR_LO];
		end
	end

	// analog control and converter data, signal processor only
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			acr_ff      <= `DPMB_WORD_RST;
			dac_ff      <= 10'h000;
			dac_load_ff <= 1'b0;
			adc_ff      <= 8'h00;
		end
		else
		begin
			dac_load_ff <= 1'b0;
			if (dsp_wr_i && (dsp_ext_i == `DPMB_EXT_ACR))
				acr_ff <= dsp_wdata_i;
			if (dsp_wr_i && (dsp_ext_i == `DPMB_EXT_CONV))
			begin
				dac_ff      <= dsp_wdata_i[9:0];
				dac_load_ff <= 1'b1;
			end
			if (adc_done_i)
				adc_ff <= adc_data_i;
		end
	end

	// routing of the three sources onto the three lines by ipr
	always_comb
	begin
		logic s_cpu;
		logic s_adc;
		logic s_dac;
		s_cpu    = dsp_mailbox_irq_ff && mask_ff[2];
		s_adc    = adc_irq_ff && mask_ff[1];
		s_dac    = dac_irq_ff && mask_ff[0];
		line_req = 3'h0;
		case (ipr_ff)
			3'h0: line_req = {s_cpu, s_adc, s_dac};
			3'h1: line_req = {s_adc, s_cpu, s_dac};
			3'h2: line_req = {s_cpu, s_dac, s_adc};
			3'h3: line_req = {s_dac, s_cpu, s_adc};
			3'h4: line_req = {s_adc, s_dac, s_cpu};
			3'h5: line_req = {s_dac, s_adc, s_cpu};
			default: line_req = 3'h0; // reserved codes raise nothing
		endcase
		if (!gen_en_ff)
			line_req = 3'h0;
	end

	dpmb_irq_arb u_arb
	(
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.req_i      (line_req),
		.isr_done_i (isr_done_i),
		.take_o     (arb_take),
		.vec_o      (arb_vec),
		.busy_o     (arb_busy)
	);

	// interrupt control read image; clear bits and bit 9 read as zero
	assign icr_rd = {dsp_mailbox_irq_ff, adc_irq_ff, dac_irq_ff, mask_ff, 1'b0,
	                 gen_en_ff, ipr_ff, 5'h00};

	// external register read, answered in the cycle after the strobe
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			dsp_rdata_ff <= `DPMB_WORD_RST;
		else if (dsp_rd_i)
		begin
			if (dsp_ext_i <= `DPMB_EXT_MBOX_LAST)
				dsp_rdata_ff <= {mbox_ff[byte_hi(dsp_ext_i[1:0], 1'b0)],
				                 mbox_ff[byte_hi(dsp_ext_i[1:0], 1'b0) | 4'h1]};
			else if (dsp_ext_i == `DPMB_EXT_ICR)
				dsp_rdata_ff <= icr_rd;
			else if (dsp_ext_i == `DPMB_EXT_CONV)
				dsp_rdata_ff <= {6'h00, adc_ff, 2'h0};
			else if (dsp_ext_i == `DPMB_EXT_ACR)
				dsp_rdata_ff <= acr_ff;
			else
				dsp_rdata_ff <= `DPMB_WORD_RST;
		end
	end

	// irq outputs registered again so every top output is a flip-flop
	logic       take_ff;
	logic [1:0] vec_ff;
	logic       busy_ff;
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			take_ff <= 1'b0;
			vec_ff  <= 2'h0;
			busy_ff <= 1'b0;
		end
		else
		begin
			take_ff <= arb_take;
			vec_ff  <= arb_vec;
			busy_ff <= arb_busy;
		end
	end

	assign cpu_rdata_o               = cpu_rdata_ff;
	assign cpu_pcr_rdata_o           = cpu_pcr_rdata_ff;
	assign control_cpu_mailbox_irq_o = cpu_irq_ff;
	assign dsp_rdata_o               = dsp_rdata_ff;
	assign dac_data_o                = dac_ff;
	assign dac_load_o                = dac_load_ff;
	assign analog_ctrl_o             = acr_ff;
	assign dsp_irq_take_o            = take_ff;
	assign dsp_irq_vec_o             = vec_ff;
	assign dsp_irq_busy_o            = busy_ff;
endmodule

// file: bench/dpmb_monitor.sv
`timescale 1ns/100ps
// port-level checks on the mailbox top; sees only its ports
module dpmb_monitor
(
	// clock and reset
	input wire logic        core_clk_i,
	input wire logic        rst_n_i,
	// control side
	input wire logic        cpu_wr_i,
	input wire logic [3:0]  cpu_addr_i,
	input wire logic [7:0]  cpu_wdata_i,
	input wire logic [7:0]  cpu_rdata_o,
	input wire logic        cpu_pcr_wr_i,
	input wire logic [1:0]  cpu_pcr_wdata_i,
	input wire logic [1:0]  cpu_pcr_rdata_o,
	input wire logic        control_cpu_mailbox_irq_o,
	// signal processor side
	input wire logic        dsp_rd_i,
	input wire logic        dsp_wr_i,
	input wire logic [2:0]  dsp_ext_i,
	input wire logic [15:0] dsp_wdata_i,
	input wire logic [15:0] dsp_rdata_o,
	// converters and interrupts
	input wire logic        adc_done_i,
	input wire logic [7:0]  adc_data_i,
	input wire logic [9:0]  dac_data_o,
	input wire logic        dac_load_o,
	input wire logic [15:0] analog_ctrl_o,
	input wire logic        isr_done_i,
	input wire logic        dsp_irq_take_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// set by an acceptance, dropped when its routine ends; a second take meanwhile is nesting
	logic armed_ff;
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || isr_done_i)
			armed_ff <= 1'b0;
		else if (dsp_irq_take_o)
			armed_ff <= 1'b1;
	end
	// register and nesting checks
	property p_adc; adc_done_i ##1 !adc_done_i ##1 (dsp_rd_i && dsp_ext_i == 3'h5 && !adc_done_i)
		|=> dsp_rdata_o == {6'h00, $past(adc_data_i, 3), 2'h0}; endproperty
	a_adc: assert property (p_adc) else $error("converter read wrong");
	property p_dac; dsp_wr_i && dsp_ext_i == 3'h5 |-> ##1 dac_data_o == 10'($past(dsp_wdata_i)) ##[0:1] dac_load_o; endproperty
	a_dac: assert property (p_dac) else $error("converter write wrong");
	property p_acr; dsp_wr_i && dsp_ext_i == 3'h6 |=> analog_ctrl_o == $past(dsp_wdata_i); endproperty
	a_acr: assert property (p_acr) else $error("analog control not loaded");
	property p_irq; dsp_wr_i && dsp_ext_i == 3'h4 && dsp_wdata_i[9] |-> ##[1:2] control_cpu_mailbox_irq_o; endproperty
	a_irq: assert property (p_irq) else $error("control irq not raised");
	property p_set; cpu_pcr_wr_i && cpu_pcr_wdata_i[1] |-> ##[1:2] cpu_pcr_rdata_o[1]; endproperty
	a_set: assert property (p_set) else $error("dsp mailbox irq not raised");
	property p_nest; dsp_irq_take_o |-> !armed_ff; endproperty
	a_nest: assert property (p_nest) else $error("nested acceptance");
	property p_own; cpu_wr_i && !cpu_addr_i[3] ##1 (!cpu_wr_i && $stable(cpu_addr_i))
		|=> cpu_rdata_o == $past(cpu_wdata_i, 2); endproperty
	a_own: assert property (p_own) else $error("outgoing byte not stored");
	property p_ro; cpu_wr_i && cpu_addr_i[3] && !dsp_wr_i ##1 (!cpu_wr_i && !dsp_wr_i && $stable(cpu_addr_i))
		|=> $stable(cpu_rdata_o); endproperty
	a_ro: assert property (p_ro) else $error("incoming byte changed by control");
	// main scenarios reached
	c_take: cover property (dsp_irq_take_o);
	c_dac: cover property (dac_load_o);
	c_irq: cover property ($rose(control_cpu_mailbox_irq_o));
endmodule
bind dpmb_top dpmb_monitor dpmb_monitor_inst (.core_clk_i, .rst_n_i, .cpu_wr_i, .cpu_addr_i, .cpu_wdata_i,
	.cpu_rdata_o, .cpu_pcr_wr_i, .cpu_pcr_wdata_i, .cpu_pcr_rdata_o, .control_cpu_mailbox_irq_o, .dsp_rd_i,
	.dsp_wr_i, .dsp_ext_i, .dsp_wdata_i, .dsp_rdata_o, .adc_done_i, .adc_data_i, .dac_data_o, .dac_load_o,
	.analog_ctrl_o, .isr_done_i, .dsp_irq_take_o);

// file: bench/dpmb_peer.sv
`timescale 1ns/100ps
// far side: control processor, signal processor and converter events
module dpmb_peer
(
	// shared clock
	input wire logic clk_i
);
	logic        cwr, pwr, drd, dwr, adone, dtick, idone;
	logic [3:0]  cadr;
	logic [7:0]  cdat, adat;
	logic [1:0]  pdat;
	logic [2:0]  dext;
	logic [15:0] ddat;
	// idle from time zero
	initial {cwr, pwr, drd, dwr, adone, dtick, idone, cadr, cdat, adat, pdat, dext, ddat} = '0;
	// just after the next rising edge
	task step;
		@(posedge clk_i);
		#1;
	endtask
	// byte write; data turned over once released so stale values never look valid
	task cpu_write(input logic [3:0] a, input logic [7:0] d);
		step();
		{cwr, cadr, cdat} = {1'b1, a, d};
		step();
		{cwr, cdat} = {1'b0, ~d};
	endtask
	// address first, byte one edge later
	task cpu_read(input logic [3:0] a);
		step();
		cadr = a;
		step();
	endtask
	// bit 0 clears the control irq, bit 1 raises the dsp one
	task pcr_write(input logic [1:0] d);
		step();
		{pwr, pdat} = {1'b1, d};
		step();
		{pwr, pdat} = 3'h0;
	endtask
	// external access; bit 9 on register 4 raises the control irq
	task dsp_acc(input logic w, input logic [2:0] e, input logic [15:0] d);
		step();
		{dwr, drd, dext, ddat} = {w, !w, e, d};
		step();
		{dwr, drd, ddat} = {2'h0, ~d};
	endtask
	// conversion done and timer pulses
	task event_pulse(input logic a, input logic t, input logic [7:0] v);
		step();
		{adone, dtick, adat} = {a, t, v};
		step();
		{adone, dtick, adat} = {2'h0, ~v};
	endtask
	task isr_end;
		step();
		idone = 1'b1;
		step();
		idone = 1'b0;
	endtask
endmodule

// file: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  cpu_rdata;
	logic [1:0]  pcr_rd, vec;
	logic        cirq, take, busy;
	logic [15:0] dsp_rdata, acr, w;
	logic [9:0]  dac_data;
	logic        dac_load;
	int          num_errors = 0;
	int          n_compared = 0;
	int          mb [16];
	int          vq [$];
	int          sq [$];
	// 250 MHz
	always #2 core_clk_i = ~core_clk_i;
	dpmb_peer dpmb_peer_inst (.clk_i(core_clk_i));
	dpmb_top dpmb_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cpu_wr_i(dpmb_peer_inst.cwr),
		.cpu_addr_i(dpmb_peer_inst.cadr), .cpu_wdata_i(dpmb_peer_inst.cdat), .cpu_rdata_o(cpu_rdata),
		.cpu_pcr_wr_i(dpmb_peer_inst.pwr), .cpu_pcr_wdata_i(dpmb_peer_inst.pdat), .cpu_pcr_rdata_o(pcr_rd),
		.control_cpu_mailbox_irq_o(cirq), .dsp_rd_i(dpmb_peer_inst.drd), .dsp_wr_i(dpmb_peer_inst.dwr),
		.dsp_ext_i(dpmb_peer_inst.dext), .dsp_wdata_i(dpmb_peer_inst.ddat), .dsp_rdata_o(dsp_rdata),
		.adc_done_i(dpmb_peer_inst.adone), .adc_data_i(dpmb_peer_inst.adat), .dac_tick_i(dpmb_peer_inst.dtick),
		.dac_data_o(dac_data), .dac_load_o(dac_load), .analog_ctrl_o(acr), .isr_done_i(dpmb_peer_inst.idone),
		.dsp_irq_take_o(take), .dsp_irq_vec_o(vec), .dsp_irq_busy_o(busy));
	task check(input string n, input logic [15:0] e, input logic [15:0] s);
		n_compared++;
		if (s !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task complete_run;
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// all sixteen bytes seen from the control side
	task read_all;
		for (int a = 0; a < 16; a++)
		begin
			dpmb_peer_inst.cpu_read(4'(a));
			check("cpu byte", 16'(mb[a]), {8'h00, cpu_rdata});
		end
	endtask
	// bounded wait for an acceptance on line v, then clear source s under control word b and end the routine
	task serve(input int v, input int s, input logic [15:0] b);
		int i;
		for (i = 0; i < 40 && take !== 1'b1; i++)
			dpmb_peer_inst.step();
		if (i == 40)
		begin
			num_errors++;
			complete_run();
		end
		check("vector", 16'(v), {14'h0, vec});
		check("busy", 16'h1, {15'h0, busy});
		dpmb_peer_inst.dsp_acc(1'b1, 3'h4, b | (16'h4 << s));
		dpmb_peer_inst.isr_end();
	endtask
	initial
	begin
		void'($urandom(54481));
		repeat (4) @(posedge core_clk_i);
		#1 rst_n_i = 1'b1;
		// outgoing bytes written, incoming ones refused
		for (int a = 0; a < 8; a++)
		begin
			mb[a] = $urandom_range(255);
			dpmb_peer_inst.cpu_write(4'(a), 8'(mb[a]));
			dpmb_peer_inst.cpu_write(4'(a + 8), 8'($urandom));
		end
		read_all();
		// a read returns outgoing bytes, a write fills incoming ones at the same address
		for (int k = 0; k < 4; k++)
		begin
			dpmb_peer_inst.dsp_acc(1'b0, 3'(k), 16'h0);
			check("word out", 16'(mb[2 * k] * 256 + mb[2 * k + 1]), dsp_rdata);
			w = 16'($urandom);
			dpmb_peer_inst.dsp_acc(1'b1, 3'(k), w);
			mb[8 + 2 * k] = w[15:8];
			mb[9 + 2 * k] = w[7:0];
			dpmb_peer_inst.dsp_acc(1'b0, 3'(k), w);
			check("word again", 16'(mb[2 * k] * 256 + mb[2 * k + 1]), dsp_rdata);
		end
		read_all();
		// converters and analog control
		w = 16'($urandom);
		dpmb_peer_inst.dsp_acc(1'b1, 3'h6, w);
		check("analog out", w, acr);
		dpmb_peer_inst.dsp_acc(1'b0, 3'h6, 16'h0);
		check("analog read", w, dsp_rdata);
		dpmb_peer_inst.dsp_acc(1'b1, 3'h5, ~w);
		check("dac", {6'h00, ~w[9:0]}, {6'h00, dac_data});
		check("dac load", 16'h1, {15'h0, dac_load});
		dpmb_peer_inst.event_pulse(1'b1, 1'b0, w[7:0]);
		dpmb_peer_inst.dsp_acc(1'b0, 3'h5, 16'h0);
		check("adc", {6'h00, w[7:0], 2'h0}, dsp_rdata);
		dpmb_peer_inst.dsp_acc(1'b0, 3'h7, w);
		check("ext7", 16'h0, dsp_rdata);
		// three requests pend while globally disabled, so all are seen at once
		dpmb_peer_inst.pcr_write(2'h2);
		dpmb_peer_inst.event_pulse(1'b0, 1'b1, 8'h00);
		check("pcr", 16'h2, {14'h0, pcr_rd});
		dpmb_peer_inst.dsp_acc(1'b0, 3'h4, 16'h0);
		check("icr", 16'he000, dsp_rdata);
		dpmb_peer_inst.dsp_acc(1'b1, 3'h4, 16'h1f00);
		vq = {2, 1, 0};
		sq = {2, 1, 0};
		while (vq.size() > 0)
			serve(vq.pop_front(), sq.pop_front(), 16'h1d00);
		check("cpu irq", 16'h3, {14'h0, pcr_rd[0], cirq});
		dpmb_peer_inst.pcr_write(2'h0);
		dpmb_peer_inst.step();
		check("cpu irq kept", 16'h1, {15'h0, cirq});
		check("busy end", 16'h0, {15'h0, busy});
		dpmb_peer_inst.pcr_write(2'h1);
		dpmb_peer_inst.step();
		dpmb_peer_inst.step();
		check("cpu irq clear", 16'h0, {13'h0, pcr_rd, cirq});
		dpmb_peer_inst.dsp_acc(1'b0, 3'h4, 16'h0);
		check("icr end", 16'h1d00, dsp_rdata);
		// routing code five: timer source on the top line, mailbox on the bottom; enable only once all pend
		dpmb_peer_inst.dsp_acc(1'b1, 3'h4, 16'h1ca0);
		dpmb_peer_inst.pcr_write(2'h2);
		dpmb_peer_inst.event_pulse(1'b1, 1'b1, 8'h5a);
		dpmb_peer_inst.dsp_acc(1'b0, 3'h4, 16'h0);
		check("icr route", 16'hfca0, dsp_rdata);
		dpmb_peer_inst.dsp_acc(1'b1, 3'h4, 16'h1da0);
		vq = {2, 1, 0};
		sq = {0, 1, 2};
		while (vq.size() > 0)
			serve(vq.pop_front(), sq.pop_front(), 16'h1da0);
		// reserved routing codes drive no line, so a pending request is never taken
		dpmb_peer_inst.dsp_acc(1'b1, 3'h4, 16'h1dc0);
		dpmb_peer_inst.event_pulse(1'b1, 1'b0, 8'ha5);
		repeat (8)
		begin
			dpmb_peer_inst.step();
			check("reserved take", 16'h0, {15'h0, take});
		end
		complete_run();
	end
endmodule
